// >>> hw/povf_pkg.sv
// Package for the overflow-flag register bank: map, fields, carriers
package povf_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int N_EVT  = 4;
  localparam int N_FLAG = 5;

  // ==========================================================
  // Field positions in a register word
  localparam int CYC_BIT = 31;
  localparam int RSV_HI  = 30;
  localparam int RSV_LO  = 4;

  // ==========================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_OVF_SET  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OVF_CLR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h10;

  // ==========================================================
  // Reset values
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              cycle;
    logic [N_EVT-1:0]  evt;
  } povf_flags_t;

  localparam povf_flags_t FLAGS_RST = 5'h00;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } povf_req_t;

  // ==========================================================
  // Word packing
  function automatic logic [DATA_W-1:0] povf_to_word(input povf_flags_t f);
    logic [DATA_W-1:0] w;
    w = WORD_ZERO;
    w[CYC_BIT] = f.cycle;
    w[N_EVT-1:0] = f.evt;
    return w;
  endfunction : povf_to_word

  function automatic povf_flags_t povf_from_word(input logic [DATA_W-1:0] w);
    povf_flags_t f;
    f.cycle = w[CYC_BIT];
    f.evt = w[N_EVT-1:0];
    return f;
  endfunction : povf_from_word

endpackage : povf_pkg

// >>> hw/povf_flags.sv
// Overflow-flag bank with set and clear views, interrupt enable and request
// Operation
// R1 - Set and clear views share one state
// R2 - Set view bit 31 sets cycle flag
// R3 - Set view bits 3..0 set event flags
// R4 - Written zero bits leave flags unchanged
// R5 - Clear view bit 31 clears cycle flag
// R6 - Clear view bits 0..3 clear event flags
// R7 - Clear view read returns current flags
// R8 - Set view read returns current flags
// R9 - Each flag one bit, resets to zero
// R10 - Clear view holds all implemented flags
// R11 - Clear bit 0 touches event 0 only
// R12 - Software sets flags only for test/restore
// R13 - Flags gated by enables raise interrupt
// R14 - Counter wrap sets flag, beats clear
// R15 - Bits 30..4 read zero, ignore writes
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module povf_flags
  import povf_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  input  wire povf_req_t        reg_req_i,
  output logic [DATA_W-1:0]     reg_rdata_o,
  input  wire logic             cycle_wrap_i,
  input  wire logic [N_EVT-1:0] event_wrap_i,
  output logic [N_EVT-1:0]      event_overflow_o,
  output logic                  cycle_overflow_o,
  output logic                  irq_o
);

  // ==========================================================
  // Decode
  povf_flags_t       flags;
  povf_flags_t       next_flags;
  povf_flags_t       irq_en;
  povf_flags_t       wmask;
  povf_flags_t       wrap;
  logic              wr_set;
  logic              wr_clr;
  logic              wr_en;
  logic [DATA_W-1:0] next_rdata;

  assign wmask  = povf_from_word(reg_req_i.wdata);
  assign wrap   = {cycle_wrap_i, event_wrap_i};
  assign wr_set = reg_req_i.wr && (reg_req_i.addr == OFS_OVF_SET);
  // Interrupt clear register is a second write-1-clear door onto the flags
  assign wr_clr = reg_req_i.wr && ((reg_req_i.addr == OFS_OVF_CLR) ||
                                   (reg_req_i.addr == OFS_IRQ_CLR));
  assign wr_en  = reg_req_i.wr && (reg_req_i.addr == OFS_IRQ_EN);

  // ==========================================================
  // Flag update, one slice per flag
  logic [N_FLAG-1:0] cur_v;
  logic [N_FLAG-1:0] nxt_v;
  logic [N_FLAG-1:0] msk_v;
  logic [N_FLAG-1:0] wrp_v;

  assign cur_v = flags;
  assign msk_v = wmask;
  assign wrp_v = wrap;

  for (genvar i = 0; i < N_FLAG; i++)
  begin : g_flag
    // Wrap wins over a same-cycle clear so no overflow is lost
    assign nxt_v[i] = wrp_v[i] |                      // R14
                      (wr_set & msk_v[i]) |           // R2 R3
                      (cur_v[i] & ~(wr_clr & msk_v[i])); // R4 R5 R6 R11
  end : g_flag

  assign next_flags = nxt_v;

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      flags <= FLAGS_RST; // R9
    end
    else if (ce_i)
    begin
      flags <= next_flags; // R1
    end
  end

  // ==========================================================
  // Interrupt enable
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      irq_en <= FLAGS_RST;
    end
    else if (ce_i && wr_en)
    begin
      irq_en <= wmask; // R15
    end
  end

  // Level request straight from registered state, no extra latency
  assign irq_o = |(flags & irq_en); // R13

  // ==========================================================
  // Read path
  always_comb
  begin
    next_rdata = WORD_ZERO;
    if (reg_req_i.rd)
    begin
      case (reg_req_i.addr)
        OFS_OVF_SET:  next_rdata = povf_to_word(flags); // R8
        OFS_OVF_CLR:  next_rdata = povf_to_word(flags); // R7 R10
        OFS_IRQ_STAT: next_rdata = povf_to_word(flags);
        OFS_IRQ_EN:   next_rdata = povf_to_word(irq_en);
        default:      next_rdata = WORD_ZERO;
      endcase
    end
  end

  // Data stands from the cycle after the strobe until the next edge with ce_i high
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      reg_rdata_o <= WORD_ZERO;
    end
    else if (ce_i)
    begin
      reg_rdata_o <= next_rdata; // R15
    end
  end

  assign cycle_overflow_o = flags.cycle;
  assign event_overflow_o = flags.evt;

  // ==========================================================
  // Checks
  logic rd_set;
  logic rd_clr;

  assign rd_set = reg_req_i.rd && (reg_req_i.addr == OFS_OVF_SET);
  assign rd_clr = reg_req_i.rd && (reg_req_i.addr == OFS_OVF_CLR);

  sequence s_set_cycle;
    ce_i && wr_set && wmask.cycle;
  endsequence

  sequence s_read_clr_view;
    ce_i && rd_clr;
  endsequence

  property p_shared_view;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_set_cycle ##1 s_read_clr_view |=> reg_rdata_o[CYC_BIT];
  endproperty
  a_shared_view: assert property (p_shared_view) // R1
    else $error("set via set view not seen in clear view");

  property p_set_cycle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_set_cycle |=> cycle_overflow_o;
  endproperty
  a_set_cycle: assert property (p_set_cycle) // R2
    else $error("cycle flag not set by set view");

  property p_set_evt;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_set |=> ((event_overflow_o & $past(wmask.evt)) == $past(wmask.evt));
  endproperty
  a_set_evt: assert property (p_set_evt) // R3
    else $error("event flag not set by set view");

  property p_zero_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && (wr_set || wr_clr) && (wmask == FLAGS_RST) && (wrap == FLAGS_RST)
      |=> $stable(flags);
  endproperty
  a_zero_hold: assert property (p_zero_hold) // R4
    else $error("zero write changed a flag");

  property p_clr_cycle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_clr && wmask.cycle && !cycle_wrap_i |=> !cycle_overflow_o;
  endproperty
  a_clr_cycle: assert property (p_clr_cycle) // R5
    else $error("cycle flag not cleared by clear view");

  property p_clr_evt;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_clr |=>
      ((event_overflow_o & $past(wmask.evt) & ~$past(event_wrap_i)) == 4'h0);
  endproperty
  a_clr_evt: assert property (p_clr_evt) // R6
    else $error("event flag not cleared by clear view");

  property p_read_clr;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_read_clr_view |=> (reg_rdata_o == povf_to_word($past(flags)));
  endproperty
  a_read_clr: assert property (p_read_clr) // R7
    else $error("clear view read mismatch");

  property p_read_set;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && rd_set |=> (reg_rdata_o == povf_to_word($past(flags)));
  endproperty
  a_read_set: assert property (p_read_set) // R8
    else $error("set view read mismatch");

  property p_reset_zero;
    @(posedge ref_clk_i)
    !reset_n_i |=> (flags == FLAGS_RST) && !irq_o && (reg_rdata_o == WORD_ZERO);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // R9
    else $error("state not zero after reset");

  property p_clr_bit0_only;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_clr && (wmask == 5'h01) && (wrap == FLAGS_RST)
      |=> !event_overflow_o[0] && ($past(flags[N_FLAG-1:1]) == flags[N_FLAG-1:1]);
  endproperty
  a_clr_bit0_only: assert property (p_clr_bit0_only) // R11
    else $error("clear of bit 0 disturbed other flags");

  property p_irq_level;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    irq_o == ((flags & irq_en) != FLAGS_RST);
  endproperty
  a_irq_level: assert property (p_irq_level) // R13
    else $error("interrupt level disagrees with flags and enables");

  property p_wrap_wins;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && (wrap != FLAGS_RST) |=> ((flags & $past(wrap)) == $past(wrap));
  endproperty
  a_wrap_wins: assert property (p_wrap_wins) // R14
    else $error("wrap did not set its flag");

  property p_rsv_zero;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    reg_rdata_o[RSV_HI:RSV_LO] == 27'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // R15
    else $error("reserved bits read non-zero");

  property p_rdata_one_cycle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !reg_req_i.rd |=> (reg_rdata_o == WORD_ZERO);
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle)
    else $error("read data outside its cycle");

  property p_ce_freeze;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !ce_i |=> $stable(flags) && $stable(irq_en) && $stable(reg_rdata_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved with clock enable low");

  // ==========================================================
  // Checks on decode, enables and interrupt
  logic rd_stat;
  logic rd_en;
  logic wr_stat;
  logic rd_known;
  logic rd_unmapped;

  assign rd_stat     = reg_req_i.rd && (reg_req_i.addr == OFS_IRQ_STAT);
  assign rd_en       = reg_req_i.rd && (reg_req_i.addr == OFS_IRQ_EN);
  assign wr_stat     = reg_req_i.wr && (reg_req_i.addr == OFS_IRQ_STAT);
  assign rd_known    = rd_set || rd_clr || rd_stat || rd_en;
  assign rd_unmapped = reg_req_i.rd && !rd_known;

  // Enable write excluded, it may drop the enable in the same edge
  sequence s_wrap_enabled;
    ce_i && !wr_en && ((wrap & irq_en) != FLAGS_RST);
  endsequence

  property p_irq_raise;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_wrap_enabled |=> irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise) // R13
    else $error("enabled wrap did not raise the interrupt");

  property p_en_write;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_en |=> (irq_en == $past(wmask));
  endproperty
  a_en_write: assert property (p_en_write) // R13
    else $error("enable write did not land");

  property p_en_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !wr_en |=> $stable(irq_en);
  endproperty
  a_en_hold: assert property (p_en_hold) // R13
    else $error("enables moved without an enable write");

  property p_read_en;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && rd_en |=> (reg_rdata_o == povf_to_word($past(irq_en)));
  endproperty
  a_read_en: assert property (p_read_en) // R13
    else $error("enable read mismatch");

  property p_read_stat;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && rd_stat |=> (reg_rdata_o == povf_to_word($past(flags)));
  endproperty
  a_read_stat: assert property (p_read_stat) // R13
    else $error("status read mismatch");

  property p_sticky;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !wr_clr |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_sticky: assert property (p_sticky) // R4
    else $error("flag dropped without a clear");

  property p_no_spurious;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !wr_set
      |=> ((flags & ~$past(flags) & ~$past(wrap)) == FLAGS_RST);
  endproperty
  a_no_spurious: assert property (p_no_spurious) // R4
    else $error("flag rose without a set or a wrap");

  property p_stat_wr_ignored;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && wr_stat && (wrap == FLAGS_RST) |=> $stable(flags) && $stable(irq_en);
  endproperty
  a_stat_wr_ignored: assert property (p_stat_wr_ignored)
    else $error("write to status register changed state");

  property p_unmapped_rd;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && rd_unmapped |=> (reg_rdata_o == WORD_ZERO);
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd)
    else $error("unmapped read returned data");

endmodule : povf_flags

`default_nettype wire

// >>> verification/perf_overflow_flag_set_clear_test.sv
// Self-checking bench for the overflow-flag register bank
`timescale 1ns/1ps
`default_nettype none

module perf_overflow_flag_set_clear_test
  import povf_pkg::*;
;
  logic              ref_clk_i;
  logic              reset_n_i;
  logic              ce_i;
  povf_req_t         req;
  logic [DATA_W-1:0] rdata;
  logic              cycle_wrap_i;
  logic [N_EVT-1:0]  event_wrap_i;
  logic [N_EVT-1:0]  evt_ovf;
  logic              cyc_ovf;
  logic              irq;
  logic [DATA_W-1:0] fw;
  logic [DATA_W-1:0] irq_s;
  logic [DATA_W-1:0] rv;
  int                error_cnt;
  int                cmp_count;
  int                cyc_cnt;

  povf_flags dut_u (
    .ref_clk_i        (ref_clk_i),
    .reset_n_i        (reset_n_i),
    .ce_i             (ce_i),
    .reg_req_i        (req),
    .reg_rdata_o      (rdata),
    .cycle_wrap_i     (cycle_wrap_i),
    .event_wrap_i     (event_wrap_i),
    .event_overflow_o (evt_ovf),
    .cycle_overflow_o (cyc_ovf),
    .irq_o            (irq)
  );

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // Access and compare tasks
  task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Snapshot taken one cycle after the strobe, when the write has landed
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk_i);
    req <= '0;
    ce_i <= 1'b1;
    cycle_wrap_i <= 1'b0;
    event_wrap_i <= '0;
    #1;
    fw = {cyc_ovf, 27'h0, evt_ovf};
    irq_s = {31'h0, irq};
    @(posedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    req <= {1'b0, 1'b1, a, WORD_ZERO};
    @(posedge ref_clk_i);
    req <= '0;
    #1;
    rv = rdata;
    @(posedge ref_clk_i);
    chk($sformatf("read %h", a), exp, rv);
  endtask : rd

  // Back-to-back pair: write, then a read in the very next cycle
  task automatic wr_rd(input logic [ADDR_W-1:0] wa, input logic [DATA_W-1:0] d,
                       input logic [ADDR_W-1:0] ra, input logic [DATA_W-1:0] exp);
    req <= {1'b1, 1'b0, wa, d};
    @(posedge ref_clk_i);
    rd(ra, exp);
  endtask : wr_rd

  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // Whole run is under a hundred cycles
  always @(posedge ref_clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    req = '0;
    cycle_wrap_i = 1'b0;
    event_wrap_i = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc_cnt = 0;
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(OFS_OVF_SET, WORD_ZERO);
    rd(OFS_OVF_CLR, WORD_ZERO);
    wr(OFS_OVF_SET, 32'h8000_0000);
    chk("flags", 32'h8000_0000, fw);
    for (int i = 0; i < N_EVT; i++)
    begin
      wr(OFS_OVF_SET, 32'h1 << i);
      chk("flags", 32'h8000_0000 | ((32'h2 << i) - 32'h1), fw);
    end
    wr(OFS_OVF_SET, 32'h7fff_fff0);
    chk("flags", 32'h8000_000f, fw);
    rd(OFS_OVF_SET, 32'h8000_000f);
    rd(OFS_OVF_CLR, 32'h8000_000f);
    wr(OFS_OVF_CLR, 32'h0000_0001);
    chk("flags", 32'h8000_000e, fw);
    wr(OFS_OVF_CLR, 32'h7fff_fff0);
    chk("flags", 32'h8000_000e, fw);
    for (int i = 1; i < N_EVT; i++)
    begin
      wr(OFS_OVF_CLR, 32'h1 << i);
      chk("flags", 32'h8000_000f & ~((32'h2 << i) - 32'h1), fw);
    end
    wr(OFS_OVF_CLR, 32'h8000_0000);
    chk("flags", WORD_ZERO, fw);
    rd(OFS_OVF_SET, WORD_ZERO);
    // Change through one view, read through the other in the next cycle
    wr_rd(OFS_OVF_SET, 32'h8000_0000, OFS_OVF_CLR, 32'h8000_0000);
    wr_rd(OFS_OVF_CLR, 32'h8000_0000, OFS_OVF_SET, WORD_ZERO);
    // Interrupt: enable event 2 and cycle, raise an unenabled flag first
    wr(OFS_IRQ_EN, 32'h8000_0004);
    rd(OFS_IRQ_EN, 32'h8000_0004);
    wr(OFS_OVF_SET, 32'h0000_0001);
    chk("irq", 32'h0, irq_s);
    wr(OFS_OVF_SET, 32'h0000_0004);
    chk("irq", 32'h1, irq_s);
    rd(OFS_IRQ_STAT, 32'h0000_0005);
    wr(OFS_IRQ_CLR, 32'h0000_0004);
    chk("irq", 32'h0, irq_s);
    // Wrap beats a same-cycle clear only on the flags that wrapped
    cycle_wrap_i <= 1'b1;
    event_wrap_i <= 4'h2;
    wr(OFS_OVF_CLR, 32'h8000_0003);
    chk("flags", 32'h8000_0002, fw);
    chk("irq", 32'h1, irq_s);
    // Strobe with the clock enable low is dropped
    ce_i <= 1'b0;
    wr(OFS_OVF_CLR, 32'h8000_0003);
    chk("flags", 32'h8000_0002, fw);
    // Status register is read-only
    wr(OFS_IRQ_STAT, 32'hffff_ffff);
    chk("flags", 32'h8000_0002, fw);
    rd(8'h20, WORD_ZERO);
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(OFS_OVF_CLR, WORD_ZERO);
    stop_test();
  end

endmodule : perf_overflow_flag_set_clear_test

`default_nettype wire
